// [inc/pan_pkg.sv]
package pan_pkg;
    // ----------------------------------------------------------------
    // management register map
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_BMC = 5'h00;
    localparam logic [4:0] REG_BMS = 5'h01;
    localparam logic [4:0] REG_ADV = 5'h04;
    localparam logic [4:0] REG_LPA = 5'h05;
    localparam logic [4:0] REG_EXP = 5'h06;
    localparam logic [4:0] REG_STS = 5'h10;
    localparam logic [4:0] REG_PCTL = 5'h19;

    // ----------------------------------------------------------------
    // field positions and values
    // ----------------------------------------------------------------
    localparam int BMC_SPEED = 13;
    localparam int BMC_NEGOTIATION_ENABLE_STRAP = 12;
    localparam int BMC_RESTART = 9;
    localparam int BMC_DUPLEX = 8;
    localparam logic [15:0] BMC_RESET = 16'h3100;
    localparam logic [15:0] BMC_RW_MASK = 16'h3100;
    localparam logic [15:0] BMS_FIXED = 16'h7849;
    localparam int BMS_AN_DONE = 5;
    localparam int BMS_RFAULT = 4;
    localparam int BMS_LINK = 2;
    localparam logic [15:0] ADV_RESET = 16'h0001;
    localparam int ABIL_LO = 5;
    localparam int ABIL_HI = 8;
    localparam int PAGE_ACK = 14;
    localparam int PAGE_RFAULT = 13;
    localparam int PAGE_NP = 15;
    localparam logic [15:0] LPA_PD_100 = 16'h0081;
    localparam logic [15:0] LPA_PD_10 = 16'h0021;
    localparam int EXP_PDF = 4;
    localparam int EXP_LP_NP = 3;
    localparam int EXP_NP_ABLE = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_LP_AN = 0;
    localparam int STS_LINK = 0;
    localparam int STS_SPEED10 = 1;
    localparam int STS_DUPLEX = 2;
    localparam int STS_AN_DONE = 4;
    localparam logic [4:0] PHY_ADDR_RESET = 5'h00;

    // ability index order: 10 half, 10 full, 100 half, 100 full;
    // indexed by {enable strap, mode high, mode low}
    localparam logic [3:0] STRAP_ABIL [8] = '{
        4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'h5, 4'hf};

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ = 100000;
    localparam int BREAK_LINK_MS = 1500;
    localparam int LINK_INHIBIT_MS = 50;
    localparam int ACK_HOLD_MS = 10;
    localparam int BREAK_CYCLES = BREAK_LINK_MS * CLK_KHZ;
    localparam int INHIBIT_CYCLES = LINK_INHIBIT_MS * CLK_KHZ;
    localparam int ACK_CYCLES = ACK_HOLD_MS * CLK_KHZ;
    localparam int TMR_W = 28;

    typedef enum logic [2:0] {
        ST_OFF, ST_BREAK, ST_ABILITY, ST_ACK, ST_CHECK, ST_GOOD
    } pan_state_e;
    typedef enum logic [1:0] {MD_IDLE, MD_HDR, MD_TA, MD_DATA} pan_mdio_e;
endpackage

// [rtl/pan_autoneg.sv]
`timescale 1ns/1ps
module pan_autoneg #(
    parameter int unsigned BREAK_CYC = pan_pkg::BREAK_CYCLES,
    parameter int unsigned INHIBIT_CYC = pan_pkg::INHIBIT_CYCLES,
    parameter int unsigned ACK_CYC = pan_pkg::ACK_CYCLES
) (
    input wire logic clk, // core clock
    input wire logic rstn, // async reset, active low
    input wire logic mdc, // management clock pin
    input wire logic mdio_i, // management data in
    output logic mdio_o, // management data out
    output logic mdio_oe, // management data enable
    input wire logic negotiation_enable_strap, // strap level
    input wire logic mode_strap_low, // strap level
    input wire logic mode_strap_high, // strap level
    input wire logic [4:0] address_strap_i, // shared pin levels
    output logic [4:0] indicator_o, // shared pin drive
    output logic [4:0] indicator_oe, // shared pin enable
    output logic rate_indicator, // high at 100 Mb/s
    input wire logic col_active, // collision seen
    input wire logic tx_active, // transmit activity
    input wire logic rx_active, // receive activity
    input wire logic link_10_ok, // 10 Mb/s receiver link
    input wire logic link_100_ok, // 100 Mb/s receiver link
    input wire logic rx_page_stb, // partner code word received
    input wire logic [15:0] rx_page, // partner code word
    output logic fast_link_pulse_burst, // send bursts
    output logic [15:0] tx_page, // code word to send
    output logic link_hold, // suppress data and pulses
    output logic speed_100, // operating speed
    output logic full_duplex, // operating duplex
    output logic link_up // link of chosen mode good
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pan_pkg::pan_state_e st_q, st_d;
    logic [pan_pkg::TMR_W-1:0] tmr_q;
    logic [15:0] bmc_q, adv_q, lpa_q;
    logic [4:0] addr_q, strap_q;
    logic [2:0] mode_strap_q;
    logic cap_q, forced_q, pd_q, pdf_q, page_rx_q, lp_an_q;
    logic [3:0] res_q;
    logic [4:0] ind_q;
    logic [4:0] reg_addr;
    logic rd_stb, wr_stb;
    logic [15:0] wr_data, rd_data;

    pan_mdio_slave u_mdio (
        .clk(clk),
        .rstn(rstn),
        .mdc(mdc),
        .mdio_i(mdio_i),
        .mdio_o(mdio_o),
        .mdio_oe(mdio_oe),
        .phy_addr(addr_q),
        .reg_addr(reg_addr),
        .rd_stb(rd_stb),
        .rd_data(rd_data),
        .wr_stb(wr_stb),
        .wr_data(wr_data)
    );

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire wr_bmc = wr_stb && reg_addr == pan_pkg::REG_BMC;
    wire wr_adv = wr_stb && reg_addr == pan_pkg::REG_ADV;
    wire wr_pctl = wr_stb && reg_addr == pan_pkg::REG_PCTL;
    wire rd_exp = rd_stb && reg_addr == pan_pkg::REG_EXP;
    wire an_on = bmc_q[pan_pkg::BMC_NEGOTIATION_ENABLE_STRAP] && !forced_q;
    wire an_set = wr_data[pan_pkg::BMC_NEGOTIATION_ENABLE_STRAP];
    // restart by bit 9, written with enable set while negotiation is already on
    wire restart = an_on && cap_q && wr_bmc && an_set
        && wr_data[pan_pkg::BMC_RESTART];
    wire [3:0] common = adv_q[pan_pkg::ABIL_HI:pan_pkg::ABIL_LO]
        & lpa_q[pan_pkg::ABIL_HI:pan_pkg::ABIL_LO];
    wire [3:0] best = common[3] ? 4'h8 : common[2] ? 4'h4 :
        common[1] ? 4'h2 : common[0] ? 4'h1 : 4'h0;
    wire pd_one = link_10_ok ^ link_100_ok;
    wire pd_both = link_10_ok & link_100_ok;
    wire res_link = (res_q[3] | res_q[2]) ? link_100_ok : link_10_ok;
    wire done = st_q == pan_pkg::ST_GOOD;
    wire tmr_zero = tmr_q == '0;

    // forced mode: strap selection while strap-forced, else control bits
    wire f_spd = forced_q ? mode_strap_q[1]
        : bmc_q[pan_pkg::BMC_SPEED];
    wire f_dup = forced_q ? mode_strap_q[0]
        : bmc_q[pan_pkg::BMC_DUPLEX];
    assign speed_100 = an_on ? (res_q[3] | res_q[2]) : f_spd;
    assign full_duplex = an_on ? (res_q[3] | res_q[1]) : f_dup;
    assign link_up = an_on ? done
        : (f_spd ? link_100_ok : link_10_ok);
    assign rate_indicator = speed_100;
    assign fast_link_pulse_burst = st_q == pan_pkg::ST_ABILITY
        || st_q == pan_pkg::ST_ACK;
    assign link_hold = st_q == pan_pkg::ST_BREAK;
    assign tx_page = {adv_q[15], st_q == pan_pkg::ST_ACK,
        adv_q[13:0]};

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    // speed/duplex are masked while a negotiation is still running
    wire sts_ok = !an_on || done;
    wire [15:0] bms = pan_pkg::BMS_FIXED
        | (16'(done) << pan_pkg::BMS_AN_DONE)
        | (16'(lpa_q[pan_pkg::PAGE_RFAULT]) << pan_pkg::BMS_RFAULT)
        | (16'(link_up) << pan_pkg::BMS_LINK);
    wire [15:0] exp = (16'(pdf_q) << pan_pkg::EXP_PDF)
        | (16'(lpa_q[pan_pkg::PAGE_NP] & lp_an_q) << pan_pkg::EXP_LP_NP)
        | (16'(adv_q[pan_pkg::PAGE_NP]) << pan_pkg::EXP_NP_ABLE)
        | (16'(page_rx_q) << pan_pkg::EXP_PAGE_RX)
        | (16'(lp_an_q) << pan_pkg::EXP_LP_AN);
    wire [15:0] sts = (16'(link_up) << pan_pkg::STS_LINK)
        | (16'(sts_ok & ~speed_100) << pan_pkg::STS_SPEED10)
        | (16'(sts_ok & full_duplex) << pan_pkg::STS_DUPLEX)
        | (16'(done) << pan_pkg::STS_AN_DONE);
    wire [15:0] bmc_rd = bmc_q;
    assign rd_data =
        reg_addr == pan_pkg::REG_BMC ? bmc_rd :
        reg_addr == pan_pkg::REG_BMS ? bms :
        reg_addr == pan_pkg::REG_ADV ? adv_q :
        reg_addr == pan_pkg::REG_LPA ? lpa_q :
        reg_addr == pan_pkg::REG_EXP ? exp :
        reg_addr == pan_pkg::REG_STS ? sts :
        reg_addr == pan_pkg::REG_PCTL ? {11'h000, addr_q} : 16'h0000;

    // ----------------------------------------------------------------
    // negotiation sequence
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            pan_pkg::ST_OFF:
                st_d = pan_pkg::ST_BREAK;
            pan_pkg::ST_BREAK:
                if (tmr_zero) st_d = pan_pkg::ST_ABILITY;
            pan_pkg::ST_ABILITY:
                if (rx_page_stb) st_d = pan_pkg::ST_ACK;
                else if (pd_one) st_d = pan_pkg::ST_CHECK;
            pan_pkg::ST_ACK:
                if (tmr_zero) st_d = (best != 4'h0) ?
                    pan_pkg::ST_CHECK : pan_pkg::ST_BREAK;
            pan_pkg::ST_CHECK:
                if (res_link) st_d = pan_pkg::ST_GOOD;
                else if (tmr_zero) st_d = pan_pkg::ST_BREAK;
            pan_pkg::ST_GOOD:
                if (!res_link) st_d = pan_pkg::ST_BREAK;
        endcase
        if (restart) st_d = pan_pkg::ST_BREAK;
        if (!an_on || !cap_q) st_d = pan_pkg::ST_OFF;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= pan_pkg::ST_OFF;
            tmr_q <= '0;
        end else begin
            st_q <= st_d;
            if (st_d != st_q || restart) begin
                unique case (st_d)
                    pan_pkg::ST_BREAK:
                        tmr_q <= pan_pkg::TMR_W'(BREAK_CYC);
                    pan_pkg::ST_ACK:
                        tmr_q <= pan_pkg::TMR_W'(ACK_CYC);
                    pan_pkg::ST_CHECK:
                        tmr_q <= pan_pkg::TMR_W'(INHIBIT_CYC);
                    default:
                        tmr_q <= '0;
                endcase
            end else if (!tmr_zero) begin
                tmr_q <= tmr_q - 1'b1;
            end
        end
    end

    // partner page, detection result, resolved mode
    wire pd_take = st_q == pan_pkg::ST_ABILITY && !rx_page_stb && pd_one;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lpa_q <= 16'h0000;
            res_q <= 4'h0;
            pd_q <= 1'b0;
            lp_an_q <= 1'b0;
        end else if (st_d == pan_pkg::ST_BREAK && st_q != st_d) begin
            res_q <= 4'h0;
            pd_q <= 1'b0;
        end else if (st_q == pan_pkg::ST_ABILITY && rx_page_stb) begin
            lpa_q <= rx_page;
            lp_an_q <= 1'b1;
        end else if (pd_take && st_d == pan_pkg::ST_CHECK) begin
            // a detected partner is taken as half duplex
            lpa_q <= link_100_ok ? pan_pkg::LPA_PD_100
                : pan_pkg::LPA_PD_10;
            res_q <= link_100_ok ? 4'h4 : 4'h1;
            pd_q <= 1'b1;
            lp_an_q <= 1'b0;
        end else if (st_q == pan_pkg::ST_ACK && tmr_zero) begin
            res_q <= best;
        end
    end

    // sticky expansion flags: a new event wins over a clearing read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pdf_q <= 1'b0;
            page_rx_q <= 1'b0;
        end else begin
            pdf_q <= (st_q == pan_pkg::ST_ABILITY && pd_both)
                || (pdf_q && !rd_exp);
            page_rx_q <= (st_q == pan_pkg::ST_ABILITY && rx_page_stb)
                || (page_rx_q && !rd_exp);
        end
    end

    // ----------------------------------------------------------------
    // control registers and strap capture
    // ----------------------------------------------------------------
    // straps are caught on the first edge after reset release, while
    // the shared pins are still undriven
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_q <= 1'b0;
            strap_q <= 5'h00;
            addr_q <= pan_pkg::PHY_ADDR_RESET;
            mode_strap_q <= 3'h0;
            forced_q <= 1'b0;
            bmc_q <= pan_pkg::BMC_RESET;
            adv_q <= pan_pkg::ADV_RESET;
        end else if (!cap_q) begin
            cap_q <= 1'b1;
            strap_q <= address_strap_i;
            addr_q <= address_strap_i;
            mode_strap_q <= {negotiation_enable_strap, mode_strap_high,
                mode_strap_low};
            forced_q <= !negotiation_enable_strap;
            adv_q[pan_pkg::ABIL_HI:pan_pkg::ABIL_LO] <=
                pan_pkg::STRAP_ABIL[{negotiation_enable_strap,
                mode_strap_high, mode_strap_low}];
        end else begin
            if (wr_bmc) begin
                bmc_q <= wr_data & pan_pkg::BMC_RW_MASK;
                if (!an_set) forced_q <= 1'b0;
            end
            if (wr_adv) adv_q <= wr_data;
            if (wr_pctl) addr_q <= wr_data[4:0];
        end
    end

    // ----------------------------------------------------------------
    // shared indicator pins
    // ----------------------------------------------------------------
    wire [4:0] ind_fn = {rx_active, tx_active, link_up,
        col_active & ~full_duplex, full_duplex};
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ind_q <= 5'h00;
        end else begin
            ind_q <= ind_fn ^ strap_q;
        end
    end
    assign indicator_o = ind_q;
    assign indicator_oe = {5{cap_q}};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_BREAK_SILENT: assert property (
        st_q == pan_pkg::ST_BREAK |-> link_hold && !fast_link_pulse_burst)
        else $error("pulses sent during break-link");
    AST_BURST_ADV: assert property (
        st_q == pan_pkg::ST_ABILITY |-> fast_link_pulse_burst
        && tx_page == adv_q)
        else $error("advertised page differs from register");
    AST_PD_CODE: assert property (
        pd_take && an_on && !restart |=> lpa_q == ($past(link_100_ok) ?
        pan_pkg::LPA_PD_100 : pan_pkg::LPA_PD_10))
        else $error("wrong partner code after detection");
    AST_PD_NOT_ABLE: assert property (
        done && pd_q |-> !exp[pan_pkg::EXP_LP_AN])
        else $error("partner-able set after parallel detect");
    AST_PD_FAULT: assert property (
        st_q == pan_pkg::ST_ABILITY && pd_both |=> pdf_q)
        else $error("parallel detect fault not flagged");
    AST_PRIORITY: assert property (
        st_q == pan_pkg::ST_ACK && tmr_zero && common[3] && an_on
        && !restart |=> res_q == 4'h8)
        else $error("highest common mode not chosen");
    AST_FORCED: assert property (
        !an_on && !forced_q |-> speed_100 == bmc_q[pan_pkg::BMC_SPEED]
        && full_duplex == bmc_q[pan_pkg::BMC_DUPLEX])
        else $error("forced mode does not follow control");
    AST_IND_POL: assert property (
        cap_q && $past(cap_q) |=> indicator_o == ($past(ind_fn) ^ strap_q))
        else $error("indicator polarity wrong");
    AST_RESTART_CLR: assert property (
        restart |=> !done ##1 !done)
        else $error("complete not cleared on restart");
    AST_ABILITY_BITS: assert property (
        bms[15:11] == 5'b01111 && bms[pan_pkg::BMS_AN_DONE] == done)
        else $error("status ability bits wrong");
    AST_STRAP_FORCED: assert property (
        forced_q |-> !an_on && speed_100 == mode_strap_q[1]
        && full_duplex == mode_strap_q[0])
        else $error("strap-forced mode not applied");
    AST_DONE_RESOLVED: assert property (
        done |-> $onehot(res_q))
        else $error("complete without a resolved mode");
    AST_LINK_LOSS: assert property (
        done && !res_link && an_on |=> st_q == pan_pkg::ST_BREAK)
        else $error("lost link did not restart negotiation");
endmodule

// [rtl/pan_mdio_slave.sv]
`timescale 1ns/1ps
module pan_mdio_slave (
    input wire logic clk, // core clock
    input wire logic rstn, // async reset, active low
    input wire logic mdc, // management clock, sampled
    input wire logic mdio_i, // management data in
    output logic mdio_o, // management data out
    output logic mdio_oe, // high while driving
    input wire logic [4:0] phy_addr, // own address
    output logic [4:0] reg_addr, // register of current frame
    output logic rd_stb, // read request, one cycle
    input wire logic [15:0] rd_data, // read data for reg_addr
    output logic wr_stb, // write strobe, one cycle
    output logic [15:0] wr_data // write data
);
    pan_pkg::pan_mdio_e st_q;
    logic mdc_q;
    logic last_q;
    logic is_rd_q;
    logic [4:0] cnt_q;
    logic [15:0] sh_q;
    wire rise = mdc & ~mdc_q;
    wire [11:0] hdr = {sh_q[10:0], mdio_i};
    wire addr_hit = hdr[9:5] == phy_addr;
    wire op_rd = hdr[11:10] == 2'b10;
    wire op_wr = hdr[11:10] == 2'b01;
    assign rd_stb = rise && st_q == pan_pkg::MD_TA && is_rd_q
        && cnt_q == 5'h00;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= pan_pkg::MD_IDLE;
            mdc_q <= 1'b1;
            last_q <= 1'b1;
            is_rd_q <= 1'b0;
            cnt_q <= 5'h00;
            sh_q <= 16'h0000;
            reg_addr <= 5'h00;
            mdio_o <= 1'b0;
            mdio_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_data <= 16'h0000;
        end else begin
            mdc_q <= mdc;
            wr_stb <= 1'b0;
            if (rise) begin
                unique case (st_q)
                    pan_pkg::MD_IDLE: begin
                        // start pattern; preamble may be suppressed
                        last_q <= mdio_i;
                        cnt_q <= 5'h00;
                        if (mdio_i && !last_q) begin
                            st_q <= pan_pkg::MD_HDR;
                        end
                    end
                    pan_pkg::MD_HDR: begin
                        sh_q <= {sh_q[14:0], mdio_i};
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == 5'd11) begin
                            reg_addr <= hdr[4:0];
                            is_rd_q <= op_rd;
                            cnt_q <= 5'h00;
                            last_q <= 1'b1;
                            st_q <= (addr_hit && (op_rd || op_wr)) ?
                                pan_pkg::MD_TA : pan_pkg::MD_IDLE;
                        end
                    end
                    pan_pkg::MD_TA: begin
                        cnt_q <= cnt_q + 5'h01;
                        if (is_rd_q && cnt_q == 5'h00) begin
                            sh_q <= rd_data;
                            mdio_o <= 1'b0;
                            mdio_oe <= 1'b1;
                        end
                        if (cnt_q == 5'h01) begin
                            cnt_q <= 5'h00;
                            st_q <= pan_pkg::MD_DATA;
                        end
                    end
                    pan_pkg::MD_DATA: begin
                        cnt_q <= cnt_q + 5'h01;
                        if (is_rd_q) begin
                            mdio_o <= sh_q[15];
                            sh_q <= {sh_q[14:0], 1'b0};
                        end else begin
                            sh_q <= {sh_q[14:0], mdio_i};
                        end
                        if (!is_rd_q && cnt_q == 5'd15) begin
                            wr_stb <= 1'b1;
                            wr_data <= {sh_q[14:0], mdio_i};
                            st_q <= pan_pkg::MD_IDLE;
                        end
                        // release the line one edge after the last bit
                        if (cnt_q == 5'd16) begin
                            mdio_oe <= 1'b0;
                            mdio_o <= 1'b0;
                            st_q <= pan_pkg::MD_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule

// [tb/pan_partner.sv]
`timescale 1ns/1ps
module pan_partner (
    input wire logic clk, // core clock
    input wire logic rstn, // async reset, active low
    input wire logic burst, // device sends bursts
    input wire logic hold, // device silent
    input wire logic [3:0] adv, // device abilities
    input wire logic [1:0] mode, // 0 off 1 neg 2 10 3 100
    input wire logic [3:0] abil, // own abilities
    output logic link_10, // 10 link seen
    output logic link_100, // 100 link seen
    output logic stb, // page pulse
    output logic [15:0] page // own code word
);
    logic [1:0] cnt_q;
    logic sent_q, got_q;
    wire logic [3:0] com = adv & abil;
    wire logic up = ~hold & ~burst & got_q;
    assign page = {7'h00, abil, 5'h01};
    // forced partners ignore bursts, as a legacy station would
    assign link_10 = ~hold & (mode == 2'h2 | up & ~com[3] & ~com[2]);
    assign link_100 = ~hold & (mode == 2'h3 | up & (com[3] | com[2]));
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {stb, cnt_q, sent_q, got_q} <= '0;
        end else begin
            stb <= burst & ~sent_q & (cnt_q == 2'h3) & (mode == 2'h1);
            cnt_q <= burst ? cnt_q + 2'h1 : 2'h0;
            sent_q <= burst & (sent_q | stb);
            got_q <= ~hold & (got_q | stb);
        end
    end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic clk, rstn, mdc, hbit, en, lo, hi, rx;
    logic [4:0] ast;
    logic [3:0] a, abil;
    logic [1:0] mode, e;
    logic [31:0] r;
    logic [15:0] d;
    int seed, error_cnt, checked, cyc;
    wire logic mdio_o, mdio_oe, rate, burst, hold, sp, fd, lk, l10, l100, stb;
    wire logic [4:0] ind, ind_oe;
    wire logic [15:0] tx_page, page;
    // open-drain style line with pull-up
    wire logic mdio_w = hbit & (~mdio_oe | mdio_o);
    pan_autoneg #(.BREAK_CYC(20), .INHIBIT_CYC(40), .ACK_CYC(10))
    pan_autoneg_inst (.clk(clk), .rstn(rstn), .mdc(mdc), .mdio_i(mdio_w),
        .mdio_o(mdio_o), .mdio_oe(mdio_oe), .negotiation_enable_strap(en),
        .mode_strap_low(lo), .mode_strap_high(hi), .address_strap_i(ast),
        .indicator_o(ind), .indicator_oe(ind_oe), .rate_indicator(rate),
        .col_active(rx), .tx_active(~rx), .rx_active(rx),
        .link_10_ok(l10), .link_100_ok(l100), .rx_page_stb(stb),
        .rx_page(page), .fast_link_pulse_burst(burst), .tx_page(tx_page),
        .link_hold(hold), .speed_100(sp), .full_duplex(fd), .link_up(lk));
    pan_partner pan_partner_inst (.clk(clk), .rstn(rstn), .burst(burst),
        .hold(hold), .adv(tx_page[8:5]), .mode(mode), .abil(abil),
        .link_10(l10), .link_100(l100), .stb(stb), .page(page));
    // ----
    // helpers
    // ----
    function logic [1:0] res(input logic [3:0] c);
        return {c[3] | c[2], c[3] | ~c[2] & c[1]};
    endfunction
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task frame(input logic [1:0] op, input logic [4:0] ra,
               input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] w;
        w = {2'b01, op, ast, ra, op[1] ? 18'h3ffff : {2'b10, wd}};
        for (int i = 0; i < 33; i++) begin
            hbit = (i < 32) ? w[31 - i] : 1'b1;
            mdc = 1'b0;
            tick(2);
            if (i > 16) rd = {rd[14:0], mdio_w};
            mdc = 1'b1;
            tick(2);
        end
    endtask
    task rdc(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] v;
        frame(2'b10, ra, 16'h0, v);
        chk(v, exp);
    endtask
    task wait_link;
        int n;
        n = 0;
        while (lk !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        chk({15'h0, lk}, 16'h1);
    endtask
    task give_verdict;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            give_verdict;
        end
    end
    initial begin
        seed = 66;
        {rstn, mdc, rx, mode, abil} = '0;
        {hbit, en, lo, hi} = 4'hf;
        r = $random(seed);
        ast = r[4:0];
        tick(2);
        rstn = 1'b1;
        tick(3);
        chk({11'h0, ind_oe}, 16'h001f);
        rdc(pan_pkg::REG_BMC, pan_pkg::BMC_RESET);
        rdc(pan_pkg::REG_BMS, pan_pkg::BMS_FIXED);
        rdc(pan_pkg::REG_ADV, pan_pkg::ADV_RESET | 16'h01e0);
        rdc(pan_pkg::REG_PCTL, {11'h0, ast});
        rdc(5'h1f, 16'h0);
        for (int k = 0; k < 3; k++) begin
            r = (k == 0) ? 32'h1ff : $random(seed);
            a = r[3:0] | 4'h1;
            abil = r[7:4] | 4'h1;
            mode = 2'h1;
            wr(pan_pkg::REG_ADV, {7'h0, a, 5'h01});
            wr(pan_pkg::REG_BMC, 16'h1200);
            wait_link;
            e = res(a & abil);
            chk({14'h0, sp, fd}, {14'h0, e});
            rdc(pan_pkg::REG_LPA, {7'h0, abil, 5'h01});
            rx = r[8];
            tick(2);
            chk({11'h0, ind ^ ast},
                {11'h0, rx, ~rx, 1'b1, rx & ~e[0], e[0]});
            rdc(pan_pkg::REG_BMS, pan_pkg::BMS_FIXED | 16'h0024);
        end
        mode = 2'h2;
        wr(pan_pkg::REG_BMC, 16'h1200);
        wait_link;
        rdc(pan_pkg::REG_LPA, pan_pkg::LPA_PD_10);
        frame(2'b10, pan_pkg::REG_EXP, 16'h0, d);
        chk({14'h0, d[pan_pkg::EXP_PDF], d[pan_pkg::EXP_LP_AN]},
            16'h0);
        rdc(pan_pkg::REG_STS, 16'h0013);
        mode = 2'h3;
        wr(pan_pkg::REG_BMC, 16'h2100);
        wait_link;
        chk({13'h0, rate, sp, fd}, 16'h0007);
        // strap-forced start, then software takes over negotiation
        rstn = 1'b0;
        {en, hi, lo} = 3'b001;
        mode = 2'h1;
        abil = 4'hf;
        tick(2);
        rstn = 1'b1;
        tick(3);
        chk({14'h0, sp, fd}, 16'h0001);
        rdc(pan_pkg::REG_BMC, pan_pkg::BMC_RESET);
        rdc(pan_pkg::REG_ADV, pan_pkg::ADV_RESET | 16'h0040);
        wr(pan_pkg::REG_BMC, 16'h1200);
        chk({14'h0, hold, lk}, 16'h0000);
        wr(pan_pkg::REG_BMC, 16'h0000);
        wr(pan_pkg::REG_BMC, 16'h1000);
        wait_link;
        chk({14'h0, sp, fd}, 16'h0001);
        give_verdict;
    end
    task wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] x;
        frame(2'b01, ra, wd, x);
    endtask
endmodule
